// File: common/pdat_defs.vh
`ifndef PDAT_DEFS_VH
`define PDAT_DEFS_VH

// register offsets (extended address space)
`define PDAT_ADDR_FREEZE   16'h031f
`define PDAT_ADDR_EQFORCE  16'h033c
`define PDAT_ADDR_DFELIM   16'h033e
`define PDAT_ADDR_LDPROG   16'h0404
`define PDAT_ADDR_RX10BT   16'h040d
`define PDAT_ADDR_HPF      16'h0416
`define PDAT_ADDR_BGTRIM   16'h0429
`define PDAT_ADDR_GAPCFG   16'h0456

// reset values
`define PDAT_RST_FREEZE    16'hfc36
`define PDAT_RST_EQFORCE   16'hec00
`define PDAT_RST_DFELIM    16'h261e
`define PDAT_RST_LDPROG    16'h0080
`define PDAT_RST_RX10BT    16'h0000
`define PDAT_RST_HPF       16'h0830
`define PDAT_RST_BGTRIM    16'h0000
`define PDAT_RST_GAPCFG    16'h0008

// writable-bit masks; zero bits are reserved or read-only
`define PDAT_WM_FREEZE     16'hfffe
`define PDAT_WM_EQFORCE    16'h007f
`define PDAT_WM_DFELIM     16'hff7f
`define PDAT_WM_LDPROG     16'hffff
`define PDAT_WM_RX10BT     16'h001f
`define PDAT_WM_HPF        16'h1fb3
`define PDAT_WM_BGTRIM     16'hff00
`define PDAT_WM_GAPCFG     16'h0008
// readable-bit masks; reserved bits read zero
`define PDAT_RM_EQFORCE    16'hff7f
`define PDAT_RM_DFELIM     16'hffff

// field positions
`define PDAT_IDLE_MSB      15
`define PDAT_IDLE_LSB      11
`define PDAT_WAKE_MSB      10
`define PDAT_WAKE_LSB      6
`define PDAT_PURGE_MSB     5
`define PDAT_PURGE_LSB     1
`define PDAT_LIMSEL_MSB    14
`define PDAT_LIMSEL_LSB    13
`define PDAT_LIMVAL_MSB    12
`define PDAT_LIMVAL_LSB    8
`define PDAT_MSE_SCALE_BIT 6
`define PDAT_DFE_SCALE_BIT 5
`define PDAT_OFFSET_MSB    4
`define PDAT_OFFSET_LSB    0
`define PDAT_GAP_BIT       3
`define PDAT_RXG_INV_BIT   3

// timing: gaps in ns, clock period in ns
`define PDAT_CLK_NS        20
`define PDAT_GAP_SHORT_NS  120
`define PDAT_GAP_LONG_NS   200
// receive gain in mV
`define PDAT_RXG_BASE_MV   10'd200
`define PDAT_RXG_STEP_MV   10'd25
`define PDAT_RXG_MAX_MV    10'd575

`endif

// File: src/pdat_regs.v
`timescale 1ns/1ns
`include "pdat_defs.vh"

module pdat_regs #(
	parameter ADDR_W = 16,
	parameter ATTN_W = 5
) (
	input  wire              clock_in,
	input  wire              rstn_in,
	input  wire [ADDR_W-1:0] addr_in,
	input  wire              wr_en_in,
	input  wire              rd_en_in,
	input  wire [15:0]       wdata_in,
	input  wire [ATTN_W-1:0] amp_attn_in,
	output reg  [15:0]       rdata_out,
	output reg               addr_hit_out,
	output wire [4:0]        idle_freeze_mask_out,
	output wire [4:0]        wake_state_hold_mask_out,
	output wire [4:0]        purge_state_hold_mask_out,
	output wire [6:0]        eq_coeff_force_out,
	output wire [1:0]        dfe_lim_sel_out,
	output wire [4:0]        dfe_lim_val_out,
	output wire              error_threshold_scale_enable_out,
	output wire              feedback_threshold_scale_enable_out,
	output wire [4:0]        attenuation_scale_offset_out,
	output reg  [ATTN_W:0]   scaled_attn_out,
	output wire [3:0]        driver_bias_out,
	output wire [3:0]        driver_common_mode_debug_out,
	output wire [2:0]        driver_power_control_out,
	output wire [4:0]        tenbase_receive_gain_code_out,
	output reg  [9:0]        rx_gain_mv_out,
	output wire [15:0]       rx_highpass_filter_out,
	output wire [7:0]        bandgap_trim_out,
	output wire              short_packet_gap_select_out,
	output reg  [3:0]        packet_gap_cycles_out
);

	// gap lengths rounded up to whole clock cycles
	localparam integer GAP_SHORT_I =
		(`PDAT_GAP_SHORT_NS + `PDAT_CLK_NS - 1) / `PDAT_CLK_NS;
	localparam integer GAP_LONG_I =
		(`PDAT_GAP_LONG_NS + `PDAT_CLK_NS - 1) / `PDAT_CLK_NS;
	localparam [3:0] GAP_SHORT_CYC = GAP_SHORT_I[3:0];
	localparam [3:0] GAP_LONG_CYC = GAP_LONG_I[3:0];

	// register storage
	reg [15:0] dsp_lpi_freeze_masks;
	reg [15:0] equalizer_force_control;
	reg [15:0] dfe_limit_and_threshold_scaling;
	reg [15:0] line_driver_program_word;
	reg [15:0] tenbase_rx_gain_trim;
	reg [15:0] rx_highpass_filter_control;
	reg [15:0] bandgap_trim_control;
	reg [15:0] general_gap_config;
	wire [9:0] rx_gain_sum;

	// merge writable bits, keep the rest
	function [15:0] pdat_merge;
		input [15:0] old_val;
		input [15:0] new_val;
		input [15:0] mask;
		begin
			pdat_merge = (old_val & ~mask) | (new_val & mask);
		end
	endfunction

	// register writes
	always @(posedge clock_in) begin
		if (!rstn_in) begin
			dsp_lpi_freeze_masks            <= `PDAT_RST_FREEZE;
			equalizer_force_control         <= `PDAT_RST_EQFORCE;
			dfe_limit_and_threshold_scaling <= `PDAT_RST_DFELIM;
			line_driver_program_word        <= `PDAT_RST_LDPROG;
			tenbase_rx_gain_trim            <= `PDAT_RST_RX10BT;
			rx_highpass_filter_control      <= `PDAT_RST_HPF;
			bandgap_trim_control            <= `PDAT_RST_BGTRIM;
			general_gap_config              <= `PDAT_RST_GAPCFG;
		end else if (wr_en_in) begin
			case (addr_in)
			`PDAT_ADDR_FREEZE: dsp_lpi_freeze_masks <= pdat_merge(
				dsp_lpi_freeze_masks, wdata_in, `PDAT_WM_FREEZE);
			`PDAT_ADDR_EQFORCE: equalizer_force_control <= pdat_merge(
				equalizer_force_control, wdata_in, `PDAT_WM_EQFORCE);
			`PDAT_ADDR_DFELIM: dfe_limit_and_threshold_scaling <= pdat_merge(
				dfe_limit_and_threshold_scaling, wdata_in, `PDAT_WM_DFELIM);
			`PDAT_ADDR_LDPROG: line_driver_program_word <= pdat_merge(
				line_driver_program_word, wdata_in, `PDAT_WM_LDPROG);
			`PDAT_ADDR_RX10BT: tenbase_rx_gain_trim <= pdat_merge(
				tenbase_rx_gain_trim, wdata_in, `PDAT_WM_RX10BT);
			`PDAT_ADDR_HPF: rx_highpass_filter_control <= pdat_merge(
				rx_highpass_filter_control, wdata_in, `PDAT_WM_HPF);
			`PDAT_ADDR_BGTRIM: bandgap_trim_control <= pdat_merge(
				bandgap_trim_control, wdata_in, `PDAT_WM_BGTRIM);
			`PDAT_ADDR_GAPCFG: general_gap_config <= pdat_merge(
				general_gap_config, wdata_in, `PDAT_WM_GAPCFG);
			default: ;
			endcase
		end
	end

	// registered read data, zero for unmapped
	always @(posedge clock_in) begin
		if (!rstn_in) begin
			rdata_out    <= 16'h0000;
			addr_hit_out <= 1'b0;
		end else if (rd_en_in) begin
			addr_hit_out <= 1'b1;
			case (addr_in)
			`PDAT_ADDR_FREEZE:  rdata_out <= dsp_lpi_freeze_masks
				& `PDAT_WM_FREEZE;
			`PDAT_ADDR_EQFORCE: rdata_out <= equalizer_force_control
				& `PDAT_RM_EQFORCE;
			`PDAT_ADDR_DFELIM:  rdata_out <= dfe_limit_and_threshold_scaling
				& `PDAT_RM_DFELIM;
			`PDAT_ADDR_LDPROG:  rdata_out <= line_driver_program_word;
			`PDAT_ADDR_RX10BT:  rdata_out <= tenbase_rx_gain_trim
				& `PDAT_WM_RX10BT;
			`PDAT_ADDR_HPF:     rdata_out <= rx_highpass_filter_control
				& `PDAT_WM_HPF;
			`PDAT_ADDR_BGTRIM:  rdata_out <= bandgap_trim_control
				& `PDAT_WM_BGTRIM;
			`PDAT_ADDR_GAPCFG:  rdata_out <= general_gap_config
				& `PDAT_WM_GAPCFG;
			default: begin
				rdata_out    <= 16'h0000;
				addr_hit_out <= 1'b0;
			end
			endcase
		end
	end

	// idle freeze mask field
	assign idle_freeze_mask_out = dsp_lpi_freeze_masks[
		`PDAT_IDLE_MSB:`PDAT_IDLE_LSB];

	// wake and purge hold mask fields
	assign wake_state_hold_mask_out = dsp_lpi_freeze_masks[
		`PDAT_WAKE_MSB:`PDAT_WAKE_LSB];
	assign purge_state_hold_mask_out = dsp_lpi_freeze_masks[
		`PDAT_PURGE_MSB:`PDAT_PURGE_LSB];

	// forced equalizer coefficient field
	assign eq_coeff_force_out = equalizer_force_control[6:0];

	// feedback coefficient cap fields
	assign dfe_lim_sel_out = dfe_limit_and_threshold_scaling[
		`PDAT_LIMSEL_MSB:`PDAT_LIMSEL_LSB];
	assign dfe_lim_val_out = dfe_limit_and_threshold_scaling[
		`PDAT_LIMVAL_MSB:`PDAT_LIMVAL_LSB];

	// threshold scaling enables
	assign error_threshold_scale_enable_out =
		dfe_limit_and_threshold_scaling[`PDAT_MSE_SCALE_BIT];
	assign feedback_threshold_scale_enable_out =
		dfe_limit_and_threshold_scaling[`PDAT_DFE_SCALE_BIT];

	// attenuation offset field
	assign attenuation_scale_offset_out = dfe_limit_and_threshold_scaling[
		`PDAT_OFFSET_MSB:`PDAT_OFFSET_LSB];

	// offset attenuation level, registered
	always @(posedge clock_in) begin
		if (!rstn_in)
			scaled_attn_out <= {(ATTN_W+1){1'b0}};
		else
			scaled_attn_out <= {1'b0, amp_attn_in}
				+ {{(ATTN_W-4){1'b0}}, attenuation_scale_offset_out};
	end

	// line driver subfields
	assign driver_bias_out = line_driver_program_word[15:12];
	assign driver_common_mode_debug_out = line_driver_program_word[11:8];
	assign driver_power_control_out = line_driver_program_word[7:5];

	// receive gain code with bit 3 inverted
	assign tenbase_receive_gain_code_out = tenbase_rx_gain_trim[4:0]
		^ (5'h01 << `PDAT_RXG_INV_BIT);

	// unclipped gain voltage; code 31 gives 975, inside ten bits
	assign rx_gain_sum = `PDAT_RXG_BASE_MV
		+ `PDAT_RXG_STEP_MV * {5'h00, tenbase_receive_gain_code_out};

	// gain voltage, held at the top of the range for codes above 15
	always @(posedge clock_in) begin
		if (!rstn_in)
			rx_gain_mv_out <= `PDAT_RXG_BASE_MV;
		else if (rx_gain_sum > `PDAT_RXG_MAX_MV)
			rx_gain_mv_out <= `PDAT_RXG_MAX_MV;
		else
			rx_gain_mv_out <= rx_gain_sum;
	end

	// high-pass filter contents, reserved bits cleared
	assign rx_highpass_filter_out = rx_highpass_filter_control & `PDAT_WM_HPF;

	// bandgap trim field
	assign bandgap_trim_out = bandgap_trim_control[15:8];

	// gap select bit
	assign short_packet_gap_select_out = general_gap_config[`PDAT_GAP_BIT];

	// gap length in clock cycles
	always @(posedge clock_in) begin
		if (!rstn_in)
			packet_gap_cycles_out <= GAP_SHORT_CYC;
		else if (short_packet_gap_select_out)
			packet_gap_cycles_out <= GAP_SHORT_CYC;
		else
			packet_gap_cycles_out <= GAP_LONG_CYC;
	end

endmodule // pdat_regs

// File: sim/pdat_regs_assertions.sv
`timescale 1ns/1ns
module pdat_chk (
	input wire        clock_in,
	input wire        rstn_in,
	input wire [15:0] addr_in,
	input wire        wr_en_in,
	input wire        rd_en_in,
	input wire [15:0] wdata_in,
	input wire [4:0]  amp_attn_in,
	input wire [15:0] rdata_out,
	input wire [4:0]  attenuation_scale_offset_out,
	input wire [5:0]  scaled_attn_out,
	input wire [4:0]  tenbase_receive_gain_code_out,
	input wire [9:0]  rx_gain_mv_out,
	input wire        short_packet_gap_select_out,
	input wire [3:0]  packet_gap_cycles_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	// writes reach the field outputs one edge later
	a_offset_write: assert property (wr_en_in && addr_in == 16'h033e |=>
		attenuation_scale_offset_out == $past(wdata_in[4:0]))
		else $error("offset field not written");
	a_gain_invert: assert property (wr_en_in && addr_in == 16'h040d |=>
		tenbase_receive_gain_code_out == ($past(wdata_in[4:0]) ^ 5'h08))
		else $error("gain code bit 3 not inverted");
	a_select_write: assert property (wr_en_in && addr_in == 16'h0456 |=>
		short_packet_gap_select_out == $past(wdata_in[3]))
		else $error("gap select not written");
	// unused upper bits of the gain register read as zero
	a_reserved_zero: assert property (rd_en_in && addr_in == 16'h040d |=>
		rdata_out[15:5] == 11'h000) else $error("reserved bits not zero");
	// derived values trail their sources by one edge
	a_attn_sum: assert property (1'b1 |=> scaled_attn_out ==
		$past(amp_attn_in) + $past(attenuation_scale_offset_out))
		else $error("scaled attenuation wrong");
	a_gain_level: assert property (1'b1 |=> rx_gain_mv_out ==
		($past(tenbase_receive_gain_code_out) > 5'd15 ? 10'd575 : 10'd200 +
		10'd25 * $past(tenbase_receive_gain_code_out)))
		else $error("gain level wrong");
	a_gap_short: assert property ($past(short_packet_gap_select_out) |->
		packet_gap_cycles_out == 4'h6) else $error("short gap wrong");
	a_gap_long: assert property (!$past(short_packet_gap_select_out) |->
		packet_gap_cycles_out == 4'ha) else $error("long gap wrong");
endmodule // pdat_chk

bind pdat_regs pdat_chk i_chk (.*);

// File: sim/tb.sv
`timescale 1ns/1ns
module tb;
	reg         clock_in = 1'b0;
	reg         rstn_in = 1'b0;
	reg         wr_en_in = 1'b0;
	reg         rd_en_in = 1'b0;
	reg  [15:0] addr_in = 16'h0000;
	reg  [15:0] wdata_in = 16'h0000;
	wire [15:0] rdata_out;
	wire [5:0]  scaled_attn;
	wire [9:0]  gain_mv;
	wire [3:0]  gap_cycles;
	reg  [4:0]  amp_attn = 5'h1f;
	wire [4:0]  idle_m, wake_m, purge_m, lim_val, offset, code;
	wire [6:0]  eq_force;
	wire [1:0]  lim_sel;
	wire [3:0]  bias, cm;
	wire [2:0]  pwr;
	wire [15:0] hpf;
	wire [7:0]  bg;
	wire        err_en, fb_en, short_sel, hit;
	integer     bad_count = 0;
	integer     check_count = 0;
	integer     i;
	// offsets, reset values, read back after all ones; index 0 is last
	localparam [127:0] adr = {16'h031f, 16'h033c, 16'h033e, 16'h0404,
		16'h040d, 16'h0416, 16'h0429, 16'h0456};
	localparam [127:0] rst = {16'hfc36, 16'hec00, 16'h261e, 16'h0080,
		16'h0000, 16'h0830, 16'h0000, 16'h0008};
	localparam [127:0] one = {16'hfffe, 16'hec7f, 16'hff7f, 16'hffff,
		16'h001f, 16'h1fb3, 16'hff00, 16'h0008};
	localparam [59:0] gm = {5'h17, 10'd575, 5'h07, 10'd575, 5'h08, 10'd200,
		5'h00, 10'd400};

	pdat_regs i_dut (.clock_in(clock_in), .rstn_in(rstn_in),
		.addr_in(addr_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
		.wdata_in(wdata_in), .amp_attn_in(amp_attn),
		.rdata_out(rdata_out),
		.addr_hit_out(hit), .idle_freeze_mask_out(idle_m),
		.wake_state_hold_mask_out(wake_m),
		.purge_state_hold_mask_out(purge_m),
		.eq_coeff_force_out(eq_force), .dfe_lim_sel_out(lim_sel),
		.dfe_lim_val_out(lim_val),
		.error_threshold_scale_enable_out(err_en),
		.feedback_threshold_scale_enable_out(fb_en),
		.attenuation_scale_offset_out(offset),
		.scaled_attn_out(scaled_attn),
		.driver_bias_out(bias), .driver_common_mode_debug_out(cm),
		.driver_power_control_out(pwr),
		.tenbase_receive_gain_code_out(code),
		.rx_gain_mv_out(gain_mv), .rx_highpass_filter_out(hpf),
		.bandgap_trim_out(bg), .short_packet_gap_select_out(short_sel),
		.packet_gap_cycles_out(gap_cycles));

	task end_of_test;
		if (bad_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input string n, input [15:0] e, input [15:0] g);
		check_count = check_count + 1;
		if (g !== e) begin
			bad_count = bad_count + 1;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	// one access: w high writes d, low reads and expects d
	task acc(input w, input [15:0] a, input [15:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		wr_en_in <= w;
		rd_en_in <= !w;
		@(posedge clock_in);
		wr_en_in <= 1'b0;
		rd_en_in <= 1'b0;
		if (!w) #1 chk("rdata", d, rdata_out);
	endtask

	// free-running 50 MHz clock
	initial forever #10 clock_in = ~clock_in;

	// cut a hang short
	initial begin
		#20000 bad_count = bad_count + 1;
		end_of_test;
	end

	// register sweep, unmapped access, gap, gain and attenuation
	initial begin
		repeat (4) @(posedge clock_in);
		rstn_in <= 1'b1;
		#1 chk("frz", 16'hfc36, {idle_m, wake_m, purge_m, 1'b0});
		chk("dfe", 16'h261e, {1'b0, lim_sel, lim_val, 1'b0, err_en,
			fb_en, offset});
		chk("drv", 16'h0080, {bias, cm, pwr, 5'h00});
		chk("misc", 16'h8800, {short_sel, hit, 1'b0, code, 1'b0,
			eq_force});
		for (i = 0; i < 8; i = i + 1) begin
			acc(0, adr[i*16+:16], rst[i*16+:16]);
			acc(1, adr[i*16+:16], 16'hffff);
			acc(0, adr[i*16+:16], one[i*16+:16]);
		end
		chk("frz", 16'hfffe, {idle_m, wake_m, purge_m, 1'b0});
		chk("dfe", 16'h7f7f, {1'b0, lim_sel, lim_val, 1'b0, err_en,
			fb_en, offset});
		chk("drv", 16'hffe0, {bias, cm, pwr, 5'h00});
		chk("misc", 16'hd77f, {short_sel, hit, 1'b0, code, 1'b0,
			eq_force});
		chk("hpf", 16'h1fb3, hpf);
		chk("trim", 16'h00ff, {8'h00, bg});
		chk("gap", 16'h0016, {11'h000, short_sel, gap_cycles});
		chk("attn", 16'h003e, {10'h000, scaled_attn});
		@(posedge clock_in);
		amp_attn <= 5'h02;
		@(posedge clock_in);
		#1 chk("attn", 16'h0021, {10'h000, scaled_attn});
		acc(1, 16'h0457, 16'h0000);
		acc(0, 16'h0456, 16'h0008);
		acc(0, 16'h0000, 16'h0000);
		chk("hit", 16'h0000, {15'h0000, hit});
		acc(1, 16'h0456, 16'h0000);
		@(posedge clock_in);
		#1 chk("gap", 16'h000a, {12'h000, gap_cycles});
		for (i = 0; i < 4; i = i + 1) begin
			acc(1, 16'h040d, {11'h000, gm[i*15+10+:5]});
			@(posedge clock_in);
			#1 chk("gain", {6'h00, gm[i*15+:10]}, {6'h00, gain_mv});
		end
		end_of_test;
	end
endmodule // tb
